// [hw/dlb_pkg.sv]
// package: register map, field layout, reset values and pattern timing for the lamp/beeper block
package dlb_pkg;
    localparam logic [9:0] LAMP_CTRL_ADDR = 10'h210;
    localparam logic [9:0] BEEP_CTRL_ADDR = 10'h211;
    localparam int ON_BIT = 0;
    localparam int PAT_LO = 1;
    localparam int PAT_HI = 2;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CTRL_WMASK = 8'h07;
    localparam logic [1:0] PAT_STEADY = 2'h0;
    localparam logic [1:0] PAT_ONE = 2'h1;
    localparam logic [1:0] PAT_TWO = 2'h2;
    localparam logic [1:0] PAT_THREE = 2'h3;
    // pattern periods in milliseconds; the on phase is a fraction of the period
    localparam int CLK_HZ = 10000000;
    localparam int LAMP_FAST_MS = 200;
    localparam int LAMP_NORM_MS = 1000;
    localparam int LAMP_SHORT_MS = 1000;
    localparam int BEEP_SHORT_MS = 1000;
    localparam int BEEP_NORM_MS = 1000;
    localparam int BEEP_LONG_MS = 2000;
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    localparam int LAMP_FAST_CYC = LAMP_FAST_MS * CYC_PER_MS;
    localparam int LAMP_NORM_CYC = LAMP_NORM_MS * CYC_PER_MS;
    localparam int LAMP_SHORT_CYC = LAMP_SHORT_MS * CYC_PER_MS;
    localparam int BEEP_SHORT_CYC = BEEP_SHORT_MS * CYC_PER_MS;
    localparam int BEEP_NORM_CYC = BEEP_NORM_MS * CYC_PER_MS;
    localparam int BEEP_LONG_CYC = BEEP_LONG_MS * CYC_PER_MS;
    localparam int CNT_W = 32;
endpackage : dlb_pkg

// [hw/dlb_pattern_gen.sv]
// one enable/pattern channel: turns an enable bit and a 2-bit pattern into an on/off output waveform
`timescale 1ns/1ps
module dlb_pattern_gen
    import dlb_pkg::*;
#(
    parameter int PER1 = 2000000,
    parameter int ON1 = 1000000,
    parameter int PER2 = 10000000,
    parameter int ON2 = 5000000,
    parameter int PER3 = 10000000,
    parameter int ON3 = 1000000
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic [1:0] pattern,
    output logic active
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] onTime;
    logic [1:0] patPrev_q;
    logic phaseOn;

    always_comb begin
        case (pattern)
            PAT_ONE: begin
                period = CNT_W'(PER1);
                onTime = CNT_W'(ON1);
            end
            PAT_TWO: begin
                period = CNT_W'(PER2);
                onTime = CNT_W'(ON2);
            end
            PAT_THREE: begin
                period = CNT_W'(PER3);
                onTime = CNT_W'(ON3);
            end
            default: begin
                period = CNT_W'(1);
                onTime = CNT_W'(1);
            end
        endcase
    end

    // restart the cycle on a pattern change or while off, so a new pattern starts in its on phase
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (!enable || pattern != patPrev_q || cnt_q >= period - CNT_W'(1)) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + CNT_W'(1);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            patPrev_q <= PAT_STEADY;
        end else begin
            patPrev_q <= pattern;
        end
    end

    assign phaseOn = (pattern == PAT_STEADY) || (cnt_q < onTime);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            active <= 1'b0;
        end else begin
            active <= enable && phaseOn;
        end
    end
endmodule : dlb_pattern_gen

// [hw/status_lamp_lamp_beeper_ctrl.sv]
// top: two host-visible control bytes driving the status lamp and the beeper
`timescale 1ns/1ps

// Overview of operation
// - lamp at 210H, beeper at 211H, read/write
// - lamp enable bit 0 turns lamp off
// - lamp field: steady, fast, normal, short flicker
// - beeper enable bit 0 silences beeper
// - beeper field: continuous, short, normal, long beeps
module status_lamp_lamp_beeper_ctrl
    import dlb_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [9:0] ioAddr,
    input wire logic ioWrStb,
    input wire logic ioRdStb,
    input wire logic [7:0] ioWrData,
    output logic [7:0] ioRdData,
    output logic ioRdValid,
    output logic statusLamp,
    output logic beeper
);
    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [7:0] lampCtrl_q;
    logic [7:0] beepCtrl_q;
    logic hitLamp;
    logic hitBeep;
    logic lamp_on_bit;
    logic [1:0] lampRate;
    logic beeper_on_bit;
    logic [1:0] beeperPattern;

    assign hitLamp = (ioAddr == LAMP_CTRL_ADDR);
    assign hitBeep = (ioAddr == BEEP_CTRL_ADDR);

    // only the three defined bits store; upper bits read back as zero
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lampCtrl_q <= CTRL_RESET;
        end else if (ioWrStb && hitLamp) begin
            lampCtrl_q <= ioWrData & CTRL_WMASK;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            beepCtrl_q <= CTRL_RESET;
        end else if (ioWrStb && hitBeep) begin
            beepCtrl_q <= ioWrData & CTRL_WMASK;
        end
    end

    // read data is registered; a miss answers zero so the bus stays defined
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ioRdData <= 8'h00;
            ioRdValid <= 1'b0;
        end else begin
            ioRdValid <= ioRdStb && (hitLamp || hitBeep);
            if (ioRdStb && hitLamp) begin
                ioRdData <= lampCtrl_q;
            end else if (ioRdStb && hitBeep) begin
                ioRdData <= beepCtrl_q;
            end else begin
                ioRdData <= 8'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------
    assign lamp_on_bit = lampCtrl_q[ON_BIT];
    assign lampRate = {lampCtrl_q[PAT_HI], lampCtrl_q[PAT_LO]};
    assign beeper_on_bit = beepCtrl_q[ON_BIT];
    assign beeperPattern = {beepCtrl_q[PAT_HI], beepCtrl_q[PAT_LO]};

    // ------------------------------------------------------------
    // waveform generators
    // ------------------------------------------------------------
    // lamp: 01 fast, 10 normal, 11 short on-pulse within normal period
    dlb_pattern_gen #(
        .PER1(LAMP_FAST_CYC),
        .ON1(LAMP_FAST_CYC / 2),
        .PER2(LAMP_NORM_CYC),
        .ON2(LAMP_NORM_CYC / 2),
        .PER3(LAMP_SHORT_CYC),
        .ON3(LAMP_SHORT_CYC / 10)
    ) u_lamp (
        .mclk(mclk),
        .rst_n(rst_n),
        .enable(lamp_on_bit),
        .pattern(lampRate),
        .active(statusLamp)
    );

    // beeper: on-time grows short < normal < long
    dlb_pattern_gen #(
        .PER1(BEEP_SHORT_CYC),
        .ON1(BEEP_SHORT_CYC / 10),
        .PER2(BEEP_NORM_CYC),
        .ON2(BEEP_NORM_CYC / 2),
        .PER3(BEEP_LONG_CYC),
        .ON3((BEEP_LONG_CYC / 4) * 3)
    ) u_beep (
        .mclk(mclk),
        .rst_n(rst_n),
        .enable(beeper_on_bit),
        .pattern(beeperPattern),
        .active(beeper)
    );

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    lamp_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ioWrStb && hitLamp |=> lampCtrl_q == ($past(ioWrData) & CTRL_WMASK))
        else $error("lamp register did not take write");
    beep_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ioWrStb && hitBeep |=> beepCtrl_q == ($past(ioWrData) & CTRL_WMASK))
        else $error("beeper register did not take write");
    lamp_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ioRdStb && hitLamp |=> ioRdValid && ioRdData == $past(lampCtrl_q))
        else $error("lamp register read mismatch");
    lamp_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !lamp_on_bit ##1 !lamp_on_bit |-> !statusLamp)
        else $error("lamp lit while disabled");
    lamp_steady_a: assert property (@(posedge mclk) disable iff (!rst_n)
        lamp_on_bit && lampRate == PAT_STEADY |=> statusLamp)
        else $error("steady lamp not lit");
    beep_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !beeper_on_bit ##1 !beeper_on_bit |-> !beeper)
        else $error("beeper sounds while disabled");
    beep_cont_a: assert property (@(posedge mclk) disable iff (!rst_n)
        beeper_on_bit && beeperPattern == PAT_STEADY |=> beeper)
        else $error("continuous beep not sounding");
    upper_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
        lampCtrl_q[7:3] == 5'h00 && beepCtrl_q[7:3] == 5'h00)
        else $error("reserved bits stored");

    // ------------------------------------------------------------
    // register bus: second byte, refusals, side effects
    // ------------------------------------------------------------
    // a miss must leave both bytes alone and answer nothing
    beep_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ioRdStb && hitBeep |=> ioRdValid && ioRdData == $past(beepCtrl_q))
        else $error("beeper register read mismatch");
    miss_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ioRdStb && !hitLamp && !hitBeep |=> !ioRdValid && ioRdData == 8'h00)
        else $error("unmapped read answered");
    miss_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ioWrStb && !hitLamp && !hitBeep |=> $stable(lampCtrl_q) && $stable(beepCtrl_q))
        else $error("unmapped write changed a register");
    idle_valid_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !ioRdStb |=> !ioRdValid)
        else $error("read valid without read strobe");
    idle_data_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !ioRdStb |=> ioRdData == 8'h00)
        else $error("read data not cleared");
    // reads have no side effects; only a write hit may move a byte
    lamp_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !(ioWrStb && hitLamp) |=> $stable(lampCtrl_q))
        else $error("lamp register changed without a write");
    beep_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !(ioWrStb && hitBeep) |=> $stable(beepCtrl_q))
        else $error("beeper register changed without a write");
    read_upper_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ioRdValid |-> ioRdData[7:3] == 5'h00)
        else $error("reserved bits read back non-zero");
    lamp_echo_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ioWrStb && hitLamp ##1 ioRdStb && hitLamp
            |=> ioRdData == ($past(ioWrData, 2) & CTRL_WMASK))
        else $error("lamp read-back differs from write");
    beep_echo_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ioWrStb && hitBeep ##1 ioRdStb && hitBeep
            |=> ioRdData == ($past(ioWrData, 2) & CTRL_WMASK))
        else $error("beeper read-back differs from write");

    // ------------------------------------------------------------
    // outputs: enable edges and pattern restarts
    // ------------------------------------------------------------
    // a fresh enable or a new pattern opens in the on phase, so software
    // sees its write at once instead of waiting out an old off phase
    lamp_start_a: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(lamp_on_bit) |=> statusLamp)
        else $error("lamp not lit after enable");
    beep_start_a: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(beeper_on_bit) |=> beeper)
        else $error("beeper silent after enable");
    lamp_restart_a: assert property (@(posedge mclk) disable iff (!rst_n)
        lamp_on_bit && $changed(lampRate) ##1 lamp_on_bit |=> statusLamp)
        else $error("new lamp rate did not open lit");
    beep_restart_a: assert property (@(posedge mclk) disable iff (!rst_n)
        beeper_on_bit && $changed(beeperPattern) ##1 beeper_on_bit |=> beeper)
        else $error("new beep pattern did not open sounding");
    // outputs are registered, so each follows its enable one edge late;
    // neither may come on by itself
    lamp_stop_a: assert property (@(posedge mclk) disable iff (!rst_n)
        $fell(lamp_on_bit) |=> !statusLamp)
        else $error("lamp still lit after disable");
    beep_stop_a: assert property (@(posedge mclk) disable iff (!rst_n)
        $fell(beeper_on_bit) |=> !beeper)
        else $error("beeper still sounds after disable");
    lamp_rise_a: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(statusLamp) |-> $past(lamp_on_bit))
        else $error("lamp lit without enable");
    beep_rise_a: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(beeper) |-> $past(beeper_on_bit))
        else $error("beeper started without enable");

    // ------------------------------------------------------------
    // coverage of the main scenarios
    // ------------------------------------------------------------
    // flicker off phases need runs far longer than the bench makes
    lamp_flicker_c: cover property (@(posedge mclk) disable iff (!rst_n)
        lamp_on_bit && lampRate == PAT_ONE && statusLamp ##1 !statusLamp);
    beep_long_c: cover property (@(posedge mclk) disable iff (!rst_n)
        beeper_on_bit && beeperPattern == PAT_THREE && beeper);
    read_beep_c: cover property (@(posedge mclk) disable iff (!rst_n)
        ioRdStb && hitBeep ##1 ioRdValid);
    lamp_restart_c: cover property (@(posedge mclk) disable iff (!rst_n)
        lamp_on_bit && $changed(lampRate));
    miss_read_c: cover property (@(posedge mclk) disable iff (!rst_n)
        ioRdStb && !hitLamp && !hitBeep);
endmodule : status_lamp_lamp_beeper_ctrl

// [dv/status_lamp_lamp_beeper_ctrl_bench.sv]
// self-checking bench for the status lamp and beeper control block
`timescale 1ns/1ps
module status_lamp_lamp_beeper_ctrl_bench import dlb_pkg::*;;
    // ----------------------------------------
    // stimulus signals and instance
    // ----------------------------------------
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [9:0] ioAddr = 10'h000;
    logic ioWrStb = 1'b0;
    logic ioRdStb = 1'b0;
    logic [7:0] ioWrData = 8'h00;
    logic [7:0] ioRdData;
    logic ioRdValid;
    logic statusLamp;
    logic beeper;
    int n_fail = 0;
    int n_compared = 0;

    always #50 mclk = ~mclk;

    status_lamp_lamp_beeper_ctrl DUT (.mclk(mclk), .rst_n(rst_n), .ioAddr(ioAddr),
        .ioWrStb(ioWrStb), .ioRdStb(ioRdStb), .ioWrData(ioWrData),
        .ioRdData(ioRdData), .ioRdValid(ioRdValid), .statusLamp(statusLamp),
        .beeper(beeper));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    task give_verdict;
        $display("compared %0d, mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict

    // strobes stay up so that a following call makes a back-to-back access
    task acc(input logic w, input logic [9:0] a, input logic [7:0] d);
        ioWrStb <= w;
        ioRdStb <= ~w;
        ioAddr <= a;
        ioWrData <= d;
        @(posedge mclk);
    endtask : acc

    task rd_chk(input logic [9:0] a, input logic [7:0] expd, input logic expv);
        acc(1'b0, a, 8'h00);
        ioRdStb <= 1'b0;
        @(negedge mclk);
        chk({7'h00, ioRdValid}, {7'h00, expv}, "read valid");
        chk(ioRdData, expd, "read data");
        @(posedge mclk);
    endtask : rd_chk

    // levels are judged two edges after the last write was taken
    task out_chk(input logic lampExp, input logic beepExp);
        ioWrStb <= 1'b0;
        ioRdStb <= 1'b0;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        chk({7'h00, statusLamp}, {7'h00, lampExp}, "lamp level");
        chk({7'h00, beeper}, {7'h00, beepExp}, "beeper level");
        @(posedge mclk);
    endtask : out_chk

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_reset;
        chk({6'h00, statusLamp, beeper}, 8'h00, "outputs in reset");
        chk({7'h00, ioRdValid}, 8'h00, "read valid in reset");
        rst_n <= 1'b1;
        rd_chk(LAMP_CTRL_ADDR, CTRL_RESET, 1'b1);
        rd_chk(BEEP_CTRL_ADDR, CTRL_RESET, 1'b1);
        $display("test reset done");
    endtask : t_reset

    task t_regs;
        acc(1'b1, LAMP_CTRL_ADDR, 8'hff);
        rd_chk(LAMP_CTRL_ADDR, 8'h07, 1'b1);
        acc(1'b1, BEEP_CTRL_ADDR, 8'hfa);
        acc(1'b1, LAMP_CTRL_ADDR, 8'h05);
        rd_chk(BEEP_CTRL_ADDR, 8'h02, 1'b1);
        rd_chk(LAMP_CTRL_ADDR, 8'h05, 1'b1);
        $display("test registers done");
    endtask : t_regs

    task t_unmapped;
        acc(1'b1, 10'h212, 8'h07);
        acc(1'b1, 10'h010, 8'h07);
        rd_chk(10'h212, 8'h00, 1'b0);
        rd_chk(10'h010, 8'h00, 1'b0);
        rd_chk(LAMP_CTRL_ADDR, 8'h05, 1'b1);
        rd_chk(BEEP_CTRL_ADDR, 8'h02, 1'b1);
        $display("test unmapped done");
    endtask : t_unmapped

    // flicker periods are far beyond the run, so only the first on phase is seen
    task t_outputs;
        for (int p = 0; p < 4; p++) begin
            acc(1'b1, LAMP_CTRL_ADDR, {5'h00, p[1:0], 1'b1});
            acc(1'b1, BEEP_CTRL_ADDR, 8'h00);
            out_chk(1'b1, 1'b0);
            acc(1'b1, BEEP_CTRL_ADDR, {5'h00, p[1:0], 1'b1});
            acc(1'b1, LAMP_CTRL_ADDR, {5'h00, p[1:0], 1'b0});
            out_chk(1'b0, 1'b1);
        end
        acc(1'b1, BEEP_CTRL_ADDR, 8'h06);
        out_chk(1'b0, 1'b0);
        $display("test outputs done");
    endtask : t_outputs

    // reset in mid-run clears both bytes and darkens both outputs at once
    task t_midreset;
        acc(1'b1, LAMP_CTRL_ADDR, 8'h01);
        acc(1'b1, BEEP_CTRL_ADDR, 8'h01);
        out_chk(1'b1, 1'b1);
        rst_n <= 1'b0;
        @(negedge mclk);
        chk({6'h00, statusLamp, beeper}, 8'h00, "outputs in mid-run reset");
        chk({7'h00, ioRdValid}, 8'h00, "read valid in mid-run reset");
        @(posedge mclk);
        rst_n <= 1'b1;
        rd_chk(LAMP_CTRL_ADDR, CTRL_RESET, 1'b1);
        rd_chk(BEEP_CTRL_ADDR, CTRL_RESET, 1'b1);
        $display("test mid-run reset done");
    endtask : t_midreset

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge mclk);
        t_reset;
        t_regs;
        t_unmapped;
        t_outputs;
        t_midreset;
        give_verdict;
    end

    initial begin
        #(100 * 50000);
        n_fail++;
        $display("unexpected at %0t ns: run too long", $time);
        give_verdict;
    end
endmodule : status_lamp_lamp_beeper_ctrl_bench
